// [logic/pfe_map.svh]
// Address map, field layout, timing counts and bar values of the front end
`ifndef PFE_MAP_SVH
`define PFE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PFE_OFF_CTRL    12'h000
`define PFE_OFF_STATUS  12'h004
`define PFE_OFF_EDGE    12'h008
`define PFE_OFF_BLACK   12'h010
`define PFE_OFF_GAIN    12'h020
`define PFE_OFF_SHROW   12'h030
`define PFE_OFF_SHCOL   12'h040
`define PFE_CTRL_TEST   0
`define PFE_CTRL_PAL    1
`define PFE_CTRL_PHASE  2
`define PFE_GAIN_RST    16'h0100
`define PFE_EDGE_RST    10'h020
`define PFE_ROW_CTR     10'h0F0
`define PFE_COL_CTR     10'h140

// ----------------------------------------------------------------------
// Video timing
// ----------------------------------------------------------------------
`define PFE_LINES_525   10'h20D
`define PFE_LINES_625   10'h271
`define PFE_LBYTES_525  11'h6B4
`define PFE_LBYTES_625  11'h6C0
`define PFE_ACT_BYTES   11'h5A0
`define PFE_SRC_W       10'h280
`define PFE_OUT_W       10'h2D0
`define PFE_IMG_LINES   9'h0F0

// ----------------------------------------------------------------------
// Bar boundaries and values, white first (byte 6 of each pack)
// ----------------------------------------------------------------------
`define PFE_BAR_EDGES {10'h066,10'h0CC,10'h134,10'h19A,10'h202,10'h268}
`define PFE_Y_525  {8'hB4,8'hA2,8'h83,8'h70,8'h54,8'h41,8'h23}
`define PFE_Y_625  {8'hEB,8'hA2,8'h83,8'h70,8'h54,8'h41,8'h23}
`define PFE_CB     {8'h80,8'h2C,8'h9C,8'h48,8'hB8,8'h64,8'hD4}
`define PFE_CR     {8'h80,8'h8E,8'h2C,8'h3A,8'hC6,8'hD4,8'h72}
`define PFE_BLK_Y  8'h10
`define PFE_BLK_C  8'h80

`endif

// [logic/pfe_pkg.sv]
// Types shared by the front end modules
`default_nettype none
package pfe_pkg;
	// Bayer colour of a sample
	typedef enum logic [1:0] {
		CH_RED   = 2'b00,
		CH_GRROW = 2'b01,
		CH_GBROW = 2'b10,
		CH_BLUE  = 2'b11
	} pfe_chan_e;
	typedef logic [9:0] pfe_pix_t;
endpackage : pfe_pkg
`default_nettype wire

// [logic/pfe_bar_gen.sv]
// Colour-bar generator with 656-style timing codes
`include "pfe_map.svh"
`default_nettype none
module pfe_bar_gen (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        palMode,
	output logic      [7:0]  vidByte,
	output logic      [9:0]  lineNum,
	output logic             fieldFlag,
	output logic             vBlank,
	output logic      [9:0]  genPix,
	output logic             genValid,
	output logic             genLineStart,
	output logic             genFrameStart
);
	logic [10:0] byteCnt;
	logic [10:0] lineBytes;
	logic [9:0]  lastLine;
	logic [10:0] actOff;
	logic [9:0]  sample;
	logic [9:0]  stretchAcc;
	logic        inAct;
	logic        darkLine;
	logic [2:0]  bar;
	logic [7:0]  yVal;
	logic [7:0]  cbVal;
	logic [7:0]  crVal;
	logic        hFlag;
	logic [7:0]  xy;
	logic [59:0] edges;
	logic [55:0] yPack;
	logic [55:0] cbPack;
	logic [55:0] crPack;
	logic [10:0] savAt;

	assign lineBytes = palMode ? `PFE_LBYTES_625 : `PFE_LBYTES_525;
	assign lastLine  = palMode ? `PFE_LINES_625 : `PFE_LINES_525;
	assign actOff    = byteCnt - (lineBytes - `PFE_ACT_BYTES);
	assign inAct     = byteCnt >= (lineBytes - `PFE_ACT_BYTES);
	assign sample    = actOff[10:1];
	assign edges     = `PFE_BAR_EDGES;
	assign yPack     = palMode ? `PFE_Y_625 : `PFE_Y_525;
	assign cbPack    = `PFE_CB;
	assign crPack    = `PFE_CR;
	assign savAt     = lineBytes - `PFE_ACT_BYTES - 11'h004;

	// ------------------------------------------------------------------
	// Byte and line counters
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			byteCnt <= 11'h000;
			lineNum <= 10'h001;
		end else if (byteCnt == lineBytes - 11'h001) begin
			byteCnt <= 11'h000;
			lineNum <= (lineNum >= lastLine) ? 10'h001 : lineNum + 10'h001;
		end else begin
			byteCnt <= byteCnt + 11'h001;
		end
	end

	// Field and blanking from the line tables
	always_comb begin
		if (palMode) begin
			fieldFlag = lineNum >= 10'h139;
			vBlank = (lineNum <= 10'h016) || (lineNum >= 10'h270) ||
				(lineNum >= 10'h137 && lineNum <= 10'h14F);
			darkLine = 1'b0;
		end else begin
			fieldFlag = (lineNum <= 10'h003) || (lineNum >= 10'h10A);
			vBlank = (lineNum <= 10'h013) ||
				(lineNum >= 10'h108 && lineNum <= 10'h11A);
			// Lines past the image in each field go dark
			darkLine = fieldFlag ?
				(lineNum - 10'h11B) >= {1'b0, `PFE_IMG_LINES} :
				(lineNum - 10'h014) >= {1'b0, `PFE_IMG_LINES};
		end
	end

	// Bar index by sample position; edges are even so pairs stay whole
	always_comb begin
		bar = 3'h6;
		for (int i = 0; i < 6; i++) begin
			if (sample < edges[(5 - i)*10 +: 10] && bar == 3'h6) begin
				bar = 3'(i);
			end
		end
		if (bar > 3'h6 || darkLine) begin
			yVal  = `PFE_BLK_Y;
			cbVal = `PFE_BLK_C;
			crVal = `PFE_BLK_C;
		end else begin
			yVal  = yPack[(6 - bar)*8 +: 8];
			cbVal = cbPack[(6 - bar)*8 +: 8];
			crVal = crPack[(6 - bar)*8 +: 8];
		end
	end

	// Timing code: H set in end-of-active code, parity bits protect F V H
	assign hFlag = byteCnt < 11'h004;
	assign xy = {1'b1, fieldFlag, vBlank, hFlag, vBlank ^ hFlag,
		fieldFlag ^ hFlag, fieldFlag ^ vBlank,
		fieldFlag ^ vBlank ^ hFlag};

	// ------------------------------------------------------------------
	// 656 byte stream
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vidByte <= 8'h00;
		end else begin
			if (byteCnt < 11'h004 || (byteCnt >= savAt && !inAct)) begin
				case (byteCnt < 11'h004 ? byteCnt[1:0] : actOff[1:0])
					2'b00:   vidByte <= 8'hFF;
					2'b11:   vidByte <= xy;
					default: vidByte <= 8'h00;
				endcase
			end else if (!inAct || vBlank) begin
				vidByte <= byteCnt[0] ? `PFE_BLK_Y : `PFE_BLK_C;
			end else begin
				case (actOff[1:0])
					2'b00:   vidByte <= cbVal;
					2'b10:   vidByte <= crVal;
					default: vidByte <= yVal;
				endcase
			end
		end
	end

	// Pipeline feed: 720 output samples map onto 640 source columns
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stretchAcc    <= 10'h000;
			genPix        <= 10'h000;
			genValid      <= 1'b0;
			genLineStart  <= 1'b0;
			genFrameStart <= 1'b0;
		end else begin
			genValid <= 1'b0;
			genLineStart  <= inAct && !vBlank && actOff == 11'h000;
			genFrameStart <= inAct && !vBlank && actOff == 11'h000 &&
				(lineNum == (palMode ? 10'h017 : 10'h014));
			if (inAct && !vBlank && actOff[0]) begin
				if (actOff == 11'h001) begin
					stretchAcc <= `PFE_SRC_W;
				end else if (stretchAcc >= `PFE_OUT_W - `PFE_SRC_W) begin
					stretchAcc <= stretchAcc + `PFE_SRC_W - `PFE_OUT_W;
				end else begin
					stretchAcc <= stretchAcc + `PFE_SRC_W;
				end
				// One source pixel per wrap and one at line start: 641 of each 720 samples
				if (actOff == 11'h001 ||
					stretchAcc >= `PFE_OUT_W - `PFE_SRC_W) begin
					genValid <= 1'b1;
					genPix   <= {yVal, 2'b00};
				end
			end
		end
	end
endmodule : pfe_bar_gen
`default_nettype wire

// [logic/pfe_front_end.sv]
// Front end: APB registers, test mux, black/gain, shading, demosaic
//
// Decided for this implementation: the APB register port and the placing of the registers.
`include "pfe_map.svh"
`default_nettype none
module pfe_front_end (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  sensPix,
	input  wire logic        sensValid,
	input  wire logic        sensLineStart,
	input  wire logic        sensFrameStart,
	output logic      [7:0]  vidByte,
	output logic      [9:0]  redOut,
	output logic      [9:0]  greenOut,
	output logic      [9:0]  blueOut,
	output logic             rgbValid
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [3:0]  ctrl_q;
	logic [9:0]  edgeThr_q;
	logic [9:0]  black_q  [4];
	logic [15:0] gain_q   [4];
	logic [15:0] shRow_q  [4];
	logic [15:0] shCol_q  [4];
	logic [9:0]  lineNum;
	logic        fieldFlag;
	logic        vBlank;
	logic [9:0]  genPix;
	logic        genValid;
	logic        genLineStart;
	logic        genFrameStart;
	logic        apbWr;
	logic        mapped;
	logic [31:0] rdMux;
	logic [1:0]  idx;

	assign apbWr  = psel && penable && pwrite && mapped;
	assign pready = 1'b1; // Zero wait states
	assign idx    = paddr[3:2];

	// Address decode and read data selection
	always_comb begin
		mapped = 1'b1;
		rdMux  = 32'h0000_0000;
		case ({paddr[11:4], 4'h0})
			`PFE_OFF_CTRL: begin
				case (paddr[3:2])
					2'b00:   rdMux = {28'h0, ctrl_q};
					2'b01:   rdMux = {20'h0, fieldFlag, vBlank, lineNum};
					2'b10:   rdMux = {22'h0, edgeThr_q};
					default: mapped = 1'b0;
				endcase
			end
			`PFE_OFF_BLACK: rdMux = {22'h0, black_q[idx]};
			`PFE_OFF_GAIN:  rdMux = {16'h0, gain_q[idx]};
			`PFE_OFF_SHROW: rdMux = {16'h0, shRow_q[idx]};
			`PFE_OFF_SHCOL: rdMux = {16'h0, shCol_q[idx]};
			default:        mapped = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end
	end

	// Unmapped or misaligned access answers with an error
	assign pslverr = psel && penable && !mapped;

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= mapped ? rdMux : 32'h0000_0000;
		end
	end

	// Control and threshold writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= 4'h0;
			edgeThr_q <= `PFE_EDGE_RST;
		end else if (apbWr && paddr[11:4] == 8'h00) begin
			if (paddr[3:2] == 2'b00) begin
				ctrl_q <= pwdata[3:0];
			end
			if (paddr[3:2] == 2'b10) begin
				edgeThr_q <= pwdata[9:0];
			end
		end
	end

	// Per-channel tables, one set per Bayer channel
	for (genvar c = 0; c < 4; c++) begin : g_chan
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				black_q[c] <= 10'h000;
				gain_q[c]  <= `PFE_GAIN_RST;
				shRow_q[c] <= 16'h0000;
				shCol_q[c] <= 16'h0000;
			end else if (apbWr && idx == 2'(c)) begin
				case ({paddr[11:4], 4'h0})
					`PFE_OFF_BLACK: black_q[c] <= pwdata[9:0];
					`PFE_OFF_GAIN:  gain_q[c]  <= pwdata[15:0];
					`PFE_OFF_SHROW: shRow_q[c] <= pwdata[15:0];
					`PFE_OFF_SHCOL: shCol_q[c] <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Test pattern and input selection
	// ------------------------------------------------------------------
	pfe_bar_gen u_bar (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.palMode       (ctrl_q[`PFE_CTRL_PAL]),
		.vidByte       (vidByte),
		.lineNum       (lineNum),
		.fieldFlag     (fieldFlag),
		.vBlank        (vBlank),
		.genPix        (genPix),
		.genValid      (genValid),
		.genLineStart  (genLineStart),
		.genFrameStart (genFrameStart)
	);

	logic            testOn;
	pfe_pkg::pfe_pix_t inPix;
	logic            inValid;
	logic            inLine;
	logic            inFrame;
	logic [9:0]      row_q;
	logic [9:0]      col_q;
	pfe_pkg::pfe_chan_e inCh;

	assign testOn  = ctrl_q[`PFE_CTRL_TEST];
	assign inPix   = testOn ? genPix : sensPix;
	assign inValid = testOn ? genValid : sensValid;
	assign inLine  = testOn ? genLineStart : sensLineStart;
	assign inFrame = testOn ? genFrameStart : sensFrameStart;
	assign inCh    = pfe_pkg::pfe_chan_e'({row_q[0], col_q[0]} ^
		ctrl_q[`PFE_CTRL_PHASE +: 2]);

	// Raster position; starts are blanking-to-image edges of the scan
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_q <= 10'h000;
			col_q <= 10'h000;
		end else begin
			if (inFrame) begin
				row_q <= 10'h000;
			end else if (inLine) begin
				row_q <= row_q + 10'h001;
			end
			if (inLine || inFrame) begin
				col_q <= 10'h000;
			end else if (inValid) begin
				col_q <= col_q + 10'h001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Black level and gain
	// ------------------------------------------------------------------
	logic [9:0]  blk_q;
	logic [1:0]  ch1_q;
	logic        v1_q;
	logic [9:0]  r1_q;
	logic [9:0]  c1_q;
	logic [25:0] gained;

	assign gained = 26'(blk_q) * 26'(gain_q[ch1_q]);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_q <= 10'h000;
			ch1_q <= 2'b00;
			v1_q  <= 1'b0;
			r1_q  <= 10'h000;
			c1_q  <= 10'h000;
		end else begin
			v1_q  <= inValid;
			ch1_q <= inCh;
			r1_q  <= row_q;
			c1_q  <= col_q;
			// Clamp to zero rather than wrap below black
			blk_q <= (inPix > black_q[inCh]) ?
				inPix - black_q[inCh] : 10'h000;
		end
	end

	// ------------------------------------------------------------------
	// Gain saturation and shading
	// ------------------------------------------------------------------
	logic [9:0]  gp_q;
	logic [1:0]  ch2_q;
	logic        v2_q;
	logic [9:0]  dr;
	logic [9:0]  dc;
	logic [25:0] shSum;
	logic [15:0] shFac_q;

	assign dr = r1_q > `PFE_ROW_CTR ? r1_q - `PFE_ROW_CTR : `PFE_ROW_CTR - r1_q;
	assign dc = c1_q > `PFE_COL_CTR ? c1_q - `PFE_COL_CTR : `PFE_COL_CTR - c1_q;
	assign shSum = 26'(shRow_q[ch1_q]) * 26'(dr) +
		26'(shCol_q[ch1_q]) * 26'(dc);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gp_q    <= 10'h000;
			ch2_q   <= 2'b00;
			v2_q    <= 1'b0;
			shFac_q <= 16'h0100;
		end else begin
			v2_q  <= v1_q;
			ch2_q <= ch1_q;
			// Gain is 8.8 fixed point; saturate at full scale
			gp_q <= (|gained[25:18]) ? 10'h3FF : gained[17:8];
			// Factor = 1.0 + weighted distance from the optical centre
			shFac_q <= (|shSum[25:24]) ? 16'hFFFF :
				16'h0100 + shSum[23:8];
		end
	end

	logic [25:0] shaded;
	logic [9:0]  sp_q;
	logic [1:0]  ch3_q;
	logic        v3_q;

	assign shaded = 26'(gp_q) * 26'(shFac_q);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_q  <= 10'h000;
			ch3_q <= 2'b00;
			v3_q  <= 1'b0;
		end else begin
			v3_q  <= v2_q;
			ch3_q <= ch2_q;
			sp_q  <= (|shaded[25:18]) ? 10'h3FF : shaded[17:8];
		end
	end

	// ------------------------------------------------------------------
	// Line buffers and 3x3 window
	// ------------------------------------------------------------------
	logic [9:0] lb1 [1024];
	logic [9:0] lb2 [1024];
	logic [9:0] wcol_q;
	logic [9:0] top_q [3];
	logic [9:0] mid_q [3];
	logic [9:0] bot_q [3];
	logic [1:0] chW_q;

	// Two lines of single-colour samples feed the interpolator
	always_ff @(posedge core_clk) begin
		if (v3_q) begin
			lb1[wcol_q] <= sp_q;
			lb2[wcol_q] <= lb1[wcol_q];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wcol_q <= 10'h000;
			chW_q  <= 2'b00;
			for (int i = 0; i < 3; i++) begin
				top_q[i] <= 10'h000;
				mid_q[i] <= 10'h000;
				bot_q[i] <= 10'h000;
			end
		end else begin
			if (v3_q && ch3_q[0] == 1'b0 && ch2_q[0] == 1'b1) begin
				wcol_q <= wcol_q + 10'h001;
			end
			if (v3_q) begin
				wcol_q <= wcol_q + 10'h001;
				chW_q  <= ch3_q;
				top_q  <= '{lb2[wcol_q], top_q[0], top_q[1]};
				mid_q  <= '{lb1[wcol_q], mid_q[0], mid_q[1]};
				bot_q  <= '{sp_q, bot_q[0], bot_q[1]};
			end
			if (v3_q && !v2_q) begin
				wcol_q <= 10'h000;
			end
		end
	end

	// ------------------------------------------------------------------
	// Edge-sensitive interpolation
	// ------------------------------------------------------------------
	logic        vW_q;
	logic [1:0]  chC;
	logic [10:0] gradH;
	logic [10:0] gradV;
	logic [9:0]  avgH;
	logic [9:0]  avgV;
	logic [9:0]  avgX;
	logic [9:0]  avgD;
	logic [9:0]  gEst;

	// Centre sits one row and one column back: both parities flip
	assign chC   = chW_q ^ 2'b11;
	assign gradH = mid_q[0] > mid_q[2] ? 11'(mid_q[0] - mid_q[2]) :
		11'(mid_q[2] - mid_q[0]);
	assign gradV = top_q[1] > bot_q[1] ? 11'(top_q[1] - bot_q[1]) :
		11'(bot_q[1] - top_q[1]);
	assign avgH = 10'((11'(mid_q[0]) + 11'(mid_q[2])) >> 1);
	assign avgV = 10'((11'(top_q[1]) + 11'(bot_q[1])) >> 1);
	assign avgX = 10'((11'(avgH) + 11'(avgV)) >> 1);
	assign avgD = 10'((12'(top_q[0]) + 12'(top_q[2]) +
		12'(bot_q[0]) + 12'(bot_q[2])) >> 2);

	// Strong gradient: follow the edge; flat area: average all four
	always_comb begin
		if (gradH > gradV && gradH - gradV > 11'(edgeThr_q)) begin
			gEst = avgV;
		end else if (gradV > gradH && gradV - gradH > 11'(edgeThr_q)) begin
			gEst = avgH;
		end else begin
			gEst = avgX;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vW_q     <= 1'b0;
			rgbValid <= 1'b0;
			redOut   <= 10'h000;
			greenOut <= 10'h000;
			blueOut  <= 10'h000;
		end else begin
			vW_q     <= v3_q;
			rgbValid <= vW_q;
			if (vW_q) begin
				case (pfe_pkg::pfe_chan_e'(chC))
					pfe_pkg::CH_RED: begin
						redOut   <= mid_q[1];
						greenOut <= gEst;
						blueOut  <= avgD;
					end
					pfe_pkg::CH_BLUE: begin
						redOut   <= avgD;
						greenOut <= gEst;
						blueOut  <= mid_q[1];
					end
					pfe_pkg::CH_GRROW: begin
						redOut   <= avgH;
						greenOut <= mid_q[1];
						blueOut  <= avgV;
					end
					default: begin
						redOut   <= avgV;
						greenOut <= mid_q[1];
						blueOut  <= avgH;
					end
				endcase
			end
		end
	end
endmodule : pfe_front_end
`default_nettype wire

// [logic/pfe_unused_guard.sv]
// Holds no logic; kept empty
`default_nettype none
`default_nettype wire

// [testbench/pfe_front_end_checker.sv]
// Port-level assertions for the front end
`default_nettype none
module pfe_front_end_checker (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [9:0]  sensPix,
	input wire logic        sensValid,
	input wire logic        sensLineStart,
	input wire logic        sensFrameStart,
	input wire logic [7:0]  vidByte,
	input wire logic [9:0]  redOut,
	input wire logic [9:0]  greenOut,
	input wire logic [9:0]  blueOut,
	input wire logic        rgbValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  b1_q, b2_q, b3_q;
	logic [10:0] cnt_q;
	logic        seen_q;
	logic        hdr;
	logic        eav;
	logic        modeWr;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Header byte follows FF 00 00 in the stream
	assign hdr = b3_q == 8'hFF && b2_q == 8'h00 && b1_q == 8'h00;
	assign eav = hdr && vidByte[4];
	assign modeWr = psel && penable && pwrite && paddr == 12'h000;
	// Byte history and line length; a mode write spoils the current line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			b3_q <= 8'h00;
			cnt_q <= 11'h000;
			seen_q <= 1'b0;
		end else begin
			b1_q <= vidByte;
			b2_q <= b1_q;
			b3_q <= b2_q;
			cnt_q <= eav ? 11'h000 : cnt_q + 11'h001;
			seen_q <= modeWr ? 1'b0 : (eav ? 1'b1 : seen_q);
		end
	end
	property p_codeSeq;
		vidByte == 8'hFF |=> vidByte == 8'h00 ##1 vidByte == 8'h00 ##1 vidByte[7];
	endproperty
	a_codeSeq: assert property (p_codeSeq)
		else $error("timing code broken");
	property p_parity;
		hdr |-> vidByte[3:0] == {vidByte[5] ^ vidByte[4], vidByte[6] ^ vidByte[4],
			vidByte[6] ^ vidByte[5], vidByte[6] ^ vidByte[5] ^ vidByte[4]};
	endproperty
	a_parity: assert property (p_parity)
		else $error("header parity wrong");
	property p_blank;
		eav |=> vidByte == 8'h80 ##1 vidByte == 8'h10;
	endproperty
	a_blank: assert property (p_blank)
		else $error("blanking bytes wrong");
	property p_savCb;
		hdr && !vidByte[4] |=> vidByte == 8'h80;
	endproperty
	a_savCb: assert property (p_savCb)
		else $error("first active byte wrong");
	property p_lineLen;
		eav && seen_q |-> cnt_q == 11'h6B3 || cnt_q == 11'h6BF;
	endproperty
	a_lineLen: assert property (p_lineLen)
		else $error("line length wrong");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("wait state inserted");
	property p_misalign;
		psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned access accepted");
	property p_errData;
		psel && penable && !pwrite && paddr >= 12'h050 |-> pslverr && prdata == 32'h0;
	endproperty
	a_errData: assert property (p_errData)
		else $error("unmapped read not refused");
	property p_latency;
		sensValid |-> ##5 rgbValid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("pixel latency wrong");
	c_eav: cover property (eav);
	c_pix: cover property (rgbValid);
	c_err: cover property (pslverr);
endmodule : pfe_front_end_checker
bind pfe_front_end pfe_front_end_checker u_chk (.core_clk(core_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sensPix(sensPix), .sensValid(sensValid),
	.sensLineStart(sensLineStart), .sensFrameStart(sensFrameStart),
	.vidByte(vidByte), .redOut(redOut), .greenOut(greenOut),
	.blueOut(blueOut), .rgbValid(rgbValid));
`default_nettype wire

// [testbench/pfe_video_sink.sv]
// Downstream sink: logs EAV line headers and bar samples of the stream
`default_nettype none
module pfe_video_sink (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] vidByte,
	output logic      [7:0] xyLog [0:31],
	output logic      [7:0] barY [0:6],
	output logic      [7:0] barCb [0:6],
	output logic      [7:0] barCr [0:6]
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EDGE [0:6] = '{0, 102, 204, 308, 410, 514, 616};
	logic [7:0]  b1_q, b2_q, b3_q;
	logic [10:0] act_q;
	logic [5:0]  eav_q;
	logic        inAct_q;
	// Only lines with V clear in the SAV code feed the bar capture, blank lines are ignored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			b3_q <= 8'h00;
			eav_q <= 6'h00;
			inAct_q <= 1'b0;
			act_q <= 11'h000;
		end else begin
			b1_q <= vidByte;
			b2_q <= b1_q;
			b3_q <= b2_q;
			if (b3_q == 8'hFF && b2_q == 8'h00 && b1_q == 8'h00) begin
				if (vidByte[4]) begin
					if (eav_q < 6'h20)
						xyLog[eav_q[4:0]] <= vidByte;
					eav_q <= eav_q + 6'h01;
					inAct_q <= 1'b0;
				end else begin
					inAct_q <= !vidByte[5];
					act_q <= 11'h000;
				end
			end else if (inAct_q) begin
				act_q <= act_q + 11'h001;
				for (int k = 0; k < 7; k++) begin
					if (act_q == 11'(2 * EDGE[k]))
						barCb[k] <= vidByte;
					if (act_q == 11'(2 * EDGE[k] + 1))
						barY[k] <= vidByte;
					if (act_q == 11'(2 * EDGE[k] + 2))
						barCr[k] <= vidByte;
				end
			end
		end
	end
endmodule : pfe_video_sink
`default_nettype wire

// [testbench/tb_pipeline_front_end_color_bars.sv]
// Self-checking bench for the front end
`default_nettype none
module tb_pipeline_front_end_color_bars;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, rgbValid;
	logic [9:0]  sensPix = 10'h000, redOut, greenOut, blueOut;
	logic        sensValid = 0, sensLineStart = 0, sensFrameStart = 0;
	logic [7:0]  vidByte, xyLog [0:31], barY [0:6], barCb [0:6], barCr [0:6];
	logic [7:0]  yTab [0:6] = '{8'hB4, 8'hA2, 8'h83, 8'h70, 8'h54, 8'h41, 8'h23};
	logic [7:0]  cbTab [0:6] = '{8'h80, 8'h2C, 8'h9C, 8'h48, 8'hB8, 8'h64, 8'hD4};
	logic [7:0]  crTab [0:6] = '{8'h80, 8'h8E, 8'h2C, 8'h3A, 8'hC6, 8'hD4, 8'h72};
	int          failCount = 0, checks = 0, n;
	always #5 core_clk = ~core_clk;
	pfe_front_end dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sensPix(sensPix),
		.sensValid(sensValid), .sensLineStart(sensLineStart),
		.sensFrameStart(sensFrameStart), .vidByte(vidByte), .redOut(redOut),
		.greenOut(greenOut), .blueOut(blueOut), .rgbValid(rgbValid));
	pfe_video_sink sink (.core_clk(core_clk), .rst_n(rst_n), .vidByte(vidByte),
		.xyLog(xyLog), .barY(barY), .barCb(barCb), .barCr(barCr));
	// Verdict and end of run
	task conclude;
		$display("checks %0d failures %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer; the wait for pready is bounded
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			failCount++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdChk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(0, a, 0);
		check(rd, e);
		check(err, ee);
	endtask : rdChk
	// Field and vertical-blank flags expected for a line number
	function automatic logic [1:0] fv(input int l, input logic pal);
		if (pal)
			return {l >= 313, !((l >= 23 && l <= 310) || (l >= 336 && l <= 623))};
		return {l <= 3 || l >= 266, !((l >= 20 && l <= 263) || l >= 283)};
	endfunction : fv
	function automatic logic [7:0] xyOf(input int l, input logic pal);
		logic [1:0] f;
		f = fv(l, pal);
		return {1'b1, f, 1'b1, ~f[0], ~f[1], ^f, ~^f};
	endfunction : xyOf
	// Poll the line status, checking its flags, until a target line
	task waitLine(input int t, input logic pal);
		for (int i = 0; i < 200; i++) begin
			apb(0, 12'h004, 0);
			check(rd[11:10], fv(rd[9:0], pal));
			if (rd[9:0] >= t)
				return;
			repeat (500) @(posedge core_clk);
		end
		failCount++;
		conclude();
	endtask : waitLine
	task frameChk(input int lo, input int hi, input logic pal);
		for (int i = lo; i <= hi; i++)
			check(xyLog[i], xyOf(i + 1, pal));
		for (int k = 0; k < 7; k++) begin
			check(barY[k], (pal && k == 0) ? 8'hEB : yTab[k]);
			check(barCb[k], cbTab[k]);
			check(barCr[k], crTab[k]);
		end
	endtask : frameChk
	// Flat three-line frame; the last output is an inner pixel
	task pixCase(input int v, input int b, input int g, input int e);
		for (int c = 0; c < 4; c++) begin
			apb(1, 12'h010 + 12'(c * 4), b);
			apb(1, 12'h020 + 12'(c * 4), g);
		end
		for (int r = 0; r < 3; r++) begin
			@(posedge core_clk);
			if (r == 0) sensFrameStart <= 1;
			else sensLineStart <= 1;
			@(posedge core_clk);
			sensFrameStart <= 0;
			sensLineStart <= 0;
			for (int c = 0; c < 8; c++) begin
				sensValid <= 1;
				sensPix <= 10'(v);
				@(posedge core_clk);
			end
			sensValid <= 0;
		end
		repeat (10) @(posedge core_clk);
		check({redOut, greenOut, blueOut}, {10'(e), 10'(e), 10'(e)});
	endtask : pixCase
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1;
		rdChk(12'h008, 32'h20, 0);
		for (int c = 0; c < 4; c++) begin
			rdChk(12'h020 + 12'(c * 4), 32'h100, 0);
			rdChk(12'h010 + 12'(c * 4), 32'h0, 0);
			rdChk(12'h030 + 12'(c * 4), 32'h0, 0);
		end
		rdChk(12'hFFC, 32'h0, 1);
		apb(1, 12'h012, 32'h5);
		check(err, 1);
		rdChk(12'h010, 32'h0, 0);
		apb(1, 12'h000, 32'h2);
		waitLine(24, 1);
		frameChk(2, 22, 1);
		// Reset in mid-run returns the generator to line 1, 525 lines
		rst_n <= 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1;
		waitLine(21, 0);
		frameChk(0, 19, 0);
		pixCase(300, 100, 'h200, 400);
		pixCase(50, 100, 'h100, 0);
		pixCase(800, 0, 'h200, 1023);
		apb(1, 12'h000, 32'h1);
		n = 0;
		repeat (4000) @(posedge core_clk) n += (rgbValid === 1'b1);
		check(n > 0, 1);
		conclude();
	end
endmodule : tb_pipeline_front_end_color_bars
`default_nettype wire
